/* common/cpu_dx_params.svh */
`ifndef CPU_DX_PARAMS_SVH
`define CPU_DX_PARAMS_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_IDX_ADD_B  8'h3a
`define OP_DBL_SHL    8'h05
`define OP_DBL_SHR    8'h04
`define OP_UMUL       8'h3d
`define OP_IDX_PUSH   8'h3c
`define OP_IDX_PULL   8'h38
`define OP_IDX_TO_SP  8'h35
`define OP_SP_TO_IDX  8'h30
`define OP_NEVER_BR   8'h21
`define LO_IDX_CMP    4'hc
`define LO_SUB        4'h3
`define LO_LDD        4'hc
`define LO_DBL_STORE  4'hd
// ----------------------------------------------------------------
// Cycle counts, reset values and PC step
// ----------------------------------------------------------------
`define CYC_SHORT   4'h3
`define CYC_PUSH    4'h4
`define CYC_PULL    4'h5
`define CYC_ARITH   4'h4
`define CYC_LDD     4'h3
`define CYC_STORE   4'h4
`define UMUL_CYCLES 10
`define RST_SP      16'h00ff
`define PC_STEP     16'h0002
`endif

/* common/cpu_dx_pkg.sv */
package cpu_dx_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } state_t;
    typedef enum logic [3:0] {
        C_NONE, C_ADD_B, C_DADD, C_DSUB, C_XCMP, C_LDD, C_DSTORE, C_DSHL,
        C_DSHR, C_UMUL, C_PUSH, C_PULL, C_X2SP, C_SP2X, C_NEVER
    } op_class_t;
endpackage

/* hdl/cpu_double_index_stack_exec.sv */
// Contract
// - Branch target: offset plus PC+2, carry propagates
// - Double accumulator is A high, B low
// - index_add_b adds unsigned B into index
// - double_add adds M:M+1 into double accumulator
// - double_shift_left: zero in, top bit to C
// - double_load reads A:B, sets flags
// - double_shift_right: zero in, bit 0 to C
// - unsigned_multiply: A times B into A:B
// - index_push: low then high, SP minus two
// - index_pull: high then low, SP plus two
// - double_store writes A then B, unchanged
// - double_subtract subtracts M:M+1 from accumulator
// - never_taken_branch: two bytes, three cycles, no jump
// - index_compare sets N Z V C from X-M
// - index_to_stack: SP gets index minus one
// - stack_to_index: index gets SP plus one
`timescale 1ns/1ps
`default_nettype none
`include "cpu_dx_params.svh"
module cpu_double_index_stack_exec #(
    parameter int unsigned UMUL_CYC = `UMUL_CYCLES
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // Decode side
    input  wire logic                   start,
    input  wire logic [7:0]             opcode,
    input  wire logic [15:0]            operand,
    input  wire logic [15:0]            pc,
    input  wire logic [7:0]             rel_offset,
    output logic                        busy,
    output logic                        done,
    output logic                        claimed,
    output logic [15:0]                 branch_target,
    // Register load from neighbouring blocks
    input  wire logic                   reg_load,
    input  wire logic [7:0]             load_a,
    input  wire logic [7:0]             load_b,
    input  wire logic [15:0]            load_x,
    input  wire logic [15:0]            load_sp,
    input  wire logic [3:0]             load_nzvc,
    // Register state
    output logic [7:0]                  accumulator_a,
    output logic [7:0]                  accumulator_b,
    output logic [15:0]                 index_reg,
    output logic [15:0]                 stack_ptr,
    output logic [3:0]                  nzvc,
    // Memory bus
    output logic [15:0]                 mem_addr,
    output logic [7:0]                  mem_wdata,
    output logic                        mem_we,
    output logic                        mem_re,
    input  wire logic [7:0]             mem_rdata
);
    import cpu_dx_pkg::*;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic op_class_t classify(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        classify = C_NONE;
        case (op)
            `OP_IDX_ADD_B: classify = C_ADD_B;
            `OP_DBL_SHL:   classify = C_DSHL;
            `OP_DBL_SHR:   classify = C_DSHR;
            `OP_UMUL:      classify = C_UMUL;
            `OP_IDX_PUSH:  classify = C_PUSH;
            `OP_IDX_PULL:  classify = C_PULL;
            `OP_IDX_TO_SP: classify = C_X2SP;
            `OP_SP_TO_IDX: classify = C_SP2X;
            `OP_NEVER_BR:  classify = C_NEVER;
            default: begin
                if (hi[3] && !hi[2] && lo == `LO_IDX_CMP) classify = C_XCMP;
                if (hi[3] && !hi[2] && lo == `LO_SUB) classify = C_DSUB;
                if (hi[3] && hi[2] && lo == `LO_SUB)  classify = C_DADD;
                if (hi[3] && hi[2] && lo == `LO_LDD)  classify = C_LDD;
                if (hi[3] && hi[2] && hi[1:0] != 2'b00 && lo == `LO_DBL_STORE) begin
                    classify = C_DSTORE;
                end
            end
        endcase
    endfunction

    // Memory-operand forms cost one cycle more for direct, two for indexed/extended; stores add none for direct, one for indexed/extended
    function automatic logic [3:0] cycles(input op_class_t c, input logic [1:0] md);
        logic [3:0] extra;
        extra = (md == 2'b00) ? 4'h0 : ((md == 2'b01) ? 4'h1 : 4'h2);
        case (c)
            C_DADD, C_DSUB, C_XCMP: cycles = `CYC_ARITH + extra;
            C_LDD:                  cycles = `CYC_LDD + extra;
            C_DSTORE:               cycles = `CYC_STORE + extra - 4'h1;
            C_PUSH:                 cycles = `CYC_PUSH;
            C_PULL:                 cycles = `CYC_PULL;
            C_UMUL:                 cycles = 4'(UMUL_CYC);
            default:               cycles = `CYC_SHORT;
        endcase
    endfunction

    state_t      state;
    op_class_t   cls;
    logic [1:0]  mode;
    logic [3:0]  cnt;
    logic [3:0]  total;
    logic [15:0] ea;
    logic [7:0]  hold_hi;
    logic [7:0]  hold_lo;

    wire op_class_t cls_in  = classify(opcode);
    wire logic      go      = start && state == ST_IDLE && cls_in != C_NONE;
    wire logic      last    = state == ST_RUN && cnt == total - 4'h1;
    wire logic      reads   = (cls == C_DADD || cls == C_DSUB || cls == C_XCMP ||
                               cls == C_LDD) && mode != 2'b00;

    assign busy    = state == ST_RUN;
    assign claimed = cls_in != C_NONE;
    assign done    = last;

    // ----------------------------------------------------------------
    // Relative branch target
    // ----------------------------------------------------------------
    // Low byte sum first, then carry or borrow fixes the high byte
    wire logic [15:0] pc_next = pc + `PC_STEP;
    wire logic [8:0]  lo_sum  = {1'b0, pc_next[7:0]} + {1'b0, rel_offset};
    wire logic [7:0]  hi_adj  = rel_offset[7] ? (lo_sum[8] ? 8'h00 : 8'hff)
                                              : {7'h00, lo_sum[8]};
    wire logic [15:0] tgt     = {pc_next[15:8] + hi_adj, lo_sum[7:0]};

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    wire logic [15:0] acc_d   = {accumulator_a, accumulator_b};
    wire logic [7:0]  lo_byte = (cnt == 4'h3) ? mem_rdata : hold_lo;
    wire logic [15:0] mem_w   = (mode == 2'b00) ? operand : {hold_hi, lo_byte};
    wire logic [15:0] lhs     = (cls == C_XCMP) ? index_reg : acc_d;
    wire logic [16:0] add_r   = {1'b0, acc_d} + {1'b0, mem_w};
    wire logic [16:0] sub_r   = {1'b0, lhs} - {1'b0, mem_w};
    wire logic [15:0] prod    = accumulator_a * accumulator_b;
    wire logic [15:0] shl     = {acc_d[14:0], 1'b0};
    wire logic [15:0] shr     = {1'b0, acc_d[15:1]};
    wire logic        add_v   = acc_d[15] == mem_w[15] && add_r[15] != acc_d[15];
    wire logic        sub_v   = lhs[15] != mem_w[15] && sub_r[15] != lhs[15];

    logic [15:0] next_d;
    logic [3:0]  next_f;
    always_comb begin
        next_d = acc_d;
        next_f = nzvc;
        case (cls)
            C_DADD: begin
                next_d = add_r[15:0];
                next_f = {add_r[15], add_r[15:0] == 16'h0000, add_v, add_r[16]};
            end
            C_DSUB: begin
                next_d = sub_r[15:0];
                next_f = {sub_r[15], sub_r[15:0] == 16'h0000, sub_v, sub_r[16]};
            end
            C_XCMP: next_f = {sub_r[15], sub_r[15:0] == 16'h0000, sub_v, sub_r[16]};
            C_LDD: begin
                next_d = mem_w;
                next_f = {mem_w[15], mem_w == 16'h0000, 1'b0, nzvc[0]};
            end
            C_DSHL: begin
                next_d = shl;
                next_f = {shl[15], shl == 16'h0000, shl[15] ^ acc_d[15], acc_d[15]};
            end
            C_DSHR: begin
                next_d = shr;
                next_f = {1'b0, shr == 16'h0000, acc_d[0], acc_d[0]};
            end
            C_UMUL: begin
                next_d = prod;
                next_f = {nzvc[3:1], prod[7]};
            end
            default: begin
                next_d = acc_d;
                next_f = nzvc;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Memory bus
    // ----------------------------------------------------------------
    // Reads return data one cycle after the strobe
    wire logic st_wr = cls == C_DSTORE && (cnt == 4'h1 || cnt == 4'h2);
    wire logic ps_wr = cls == C_PUSH && (cnt == 4'h1 || cnt == 4'h2);
    wire logic ld_rd = reads && (cnt == 4'h1 || cnt == 4'h2);
    wire logic pl_rd = cls == C_PULL && (cnt == 4'h2 || cnt == 4'h3);

    assign mem_we    = busy && (st_wr || ps_wr);
    assign mem_re    = busy && (ld_rd || pl_rd);
    assign mem_addr  = (cls == C_PUSH || cls == C_PULL) ? stack_ptr
                     : ((cnt == 4'h2) ? ea + 16'h0001 : ea);
    assign mem_wdata = (cls == C_PUSH) ? ((cnt == 4'h1) ? index_reg[7:0] : index_reg[15:8])
                     : ((cnt == 4'h1) ? accumulator_a : accumulator_b);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            cls   <= C_NONE;
            mode  <= 2'b00;
            cnt   <= 4'h0;
            total <= 4'h0;
            ea    <= 16'h0000;
        end else if (go) begin
            state <= ST_RUN;
            cls   <= cls_in;
            mode  <= opcode[5:4];
            cnt   <= 4'h1;
            total <= cycles(cls_in, opcode[5:4]);
            ea    <= operand;
        end else if (last) begin
            state <= ST_IDLE;
            cls   <= C_NONE;
        end else if (busy) begin
            cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            branch_target <= 16'h0000;
            hold_hi       <= 8'h00;
            hold_lo       <= 8'h00;
        end else begin
            if (go) branch_target <= tgt;
            if (busy && cnt == 4'h2) hold_hi <= mem_rdata;
            if (busy && cnt == 4'h3) hold_lo <= mem_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            accumulator_a <= 8'h00;
            accumulator_b <= 8'h00;
            index_reg     <= 16'h0000;
            stack_ptr     <= `RST_SP;
            nzvc          <= 4'h0;
        end else if (reg_load && !busy) begin
            accumulator_a <= load_a;
            accumulator_b <= load_b;
            index_reg     <= load_x;
            stack_ptr     <= load_sp;
            nzvc          <= load_nzvc;
        end else if (busy) begin
            if (ps_wr) stack_ptr <= stack_ptr - 16'h0001;
            if (cls == C_PULL && cnt <= 4'h2) stack_ptr <= stack_ptr + 16'h0001;
            if (last) begin
                {accumulator_a, accumulator_b} <= next_d;
                nzvc <= next_f;
                case (cls)
                    C_ADD_B: index_reg <= index_reg + {8'h00, accumulator_b};
                    C_X2SP:  stack_ptr <= index_reg - 16'h0001;
                    C_SP2X:  index_reg <= stack_ptr + 16'h0001;
                    // Pull reads start a cycle late, so its high byte sits in hold_lo
                    C_PULL:  index_reg <= {hold_lo, mem_rdata};
                    default: index_reg <= index_reg;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_go(op_class_t c);
        go && cls_in == c;
    endsequence
    // Immediate forms only: the operand word is the data itself
    sequence s_imm_go(op_class_t c);
        go && cls_in == c && opcode[5:4] == 2'b00;
    endsequence
    // Low byte first at the old pointer, then high byte one below
    sequence s_push_writes;
        (mem_we && mem_wdata == index_reg[7:0]) ##1
        (mem_we && mem_wdata == index_reg[15:8]);
    endsequence

    // Results land at the done edge, so one-deep history holds the old values
    a_add_b_index: assert property (s_go(C_ADD_B) |-> ##3
        index_reg == $past(index_reg) + {8'h00, $past(accumulator_b)} &&
        nzvc == $past(nzvc))
        else $error("index add of B wrong");
    a_x_to_sp_load: assert property (s_go(C_X2SP) |-> ##3
        stack_ptr == $past(index_reg) - 16'h0001)
        else $error("index to stack wrong");
    a_sp_to_x_load: assert property (s_go(C_SP2X) |-> ##3
        index_reg == $past(stack_ptr) + 16'h0001)
        else $error("stack to index wrong");
    a_push_sp_drop: assert property (s_go(C_PUSH) |-> ##1 s_push_writes
        ##1 done ##1 stack_ptr == $past(stack_ptr, 3) - 16'h0002)
        else $error("index push sequence wrong");
    a_pull_sp_rise: assert property (s_go(C_PULL) |-> ##4 done
        ##1 stack_ptr == $past(stack_ptr, 4) + 16'h0002)
        else $error("index pull sequence wrong");
    a_never_three_cyc: assert property (s_go(C_NEVER) |-> (!mem_we && !mem_re) [*3]
        ##0 done ##1 index_reg == $past(index_reg))
        else $error("never taken branch wrong");
    a_umul_product: assert property (s_go(C_UMUL) |-> ##9 done
        ##1 {accumulator_a, accumulator_b} == $past(prod))
        else $error("multiply result wrong");
    a_shift_carry: assert property (s_go(C_DSHL) |-> ##3
        nzvc[0] == $past(accumulator_a[7]) && accumulator_b[0] == 1'b0)
        else $error("double left shift wrong");
    a_shr_carry: assert property (s_go(C_DSHR) |-> ##3
        nzvc[0] == $past(accumulator_b[0]) && accumulator_a[7] == 1'b0)
        else $error("double right shift wrong");
    a_dload_flags: assert property (s_imm_go(C_LDD) |-> ##3
        {accumulator_a, accumulator_b} == $past(operand, 3) &&
        nzvc[3:1] == {$past(operand[15], 3), $past(operand, 3) == 16'h0000, 1'b0})
        else $error("double load wrong");
    a_dadd_sum: assert property (s_imm_go(C_DADD) |-> ##4
        {accumulator_a, accumulator_b} ==
        $past({accumulator_a, accumulator_b}, 4) + $past(operand, 4))
        else $error("double add wrong");
    a_foreign_idle: assert property (start && !claimed && !busy |=>
        !busy && !mem_we && !mem_re)
        else $error("foreign opcode started work");
    a_branch_reach: assert property (go |=>
        branch_target == $past(pc) + 16'h0002 + {{8{$past(rel_offset[7])}}, $past(rel_offset)})
        else $error("branch target wrong");
endmodule
`default_nettype wire

/* dv/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // Clock
    input  wire logic        core_clk,
    // Bus
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    output logic [7:0]       mem_rdata
);
    logic [7:0] mem [0:65535];
    initial mem_rdata = 8'h00;
    // Outside a read the line flips so stale data never matches
    always @(posedge core_clk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (mem_re) mem_rdata <= mem[mem_addr];
        else mem_rdata <= ~mem_rdata;
    end
endmodule
`default_nettype wire

/* dv/cpu_double_index_stack_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_double_index_stack_exec_tb;
    logic core_clk, reset, start, reg_load, busy, done, claimed;
    logic [7:0] opcode, rel_offset, load_a, load_b, acc_a, acc_b;
    logic [15:0] operand, pc, load_x, load_sp, target, ix, sp;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    logic mem_we, mem_re;
    logic [3:0] load_nzvc, nzvc;
    logic [7:0] cx [4];
    int failures, check_count, cyc, bus_n, b0;
    cpu_double_index_stack_exec #(.UMUL_CYC(10)) dut (
        .core_clk(core_clk), .reset(reset), .start(start), .opcode(opcode),
        .operand(operand), .pc(pc), .rel_offset(rel_offset), .busy(busy),
        .done(done), .claimed(claimed), .branch_target(target),
        .reg_load(reg_load), .load_a(load_a), .load_b(load_b),
        .load_x(load_x), .load_sp(load_sp), .load_nzvc(load_nzvc),
        .accumulator_a(acc_a), .accumulator_b(acc_b), .index_reg(ix),
        .stack_ptr(sp), .nzvc(nzvc), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .mem_rdata(mem_rdata));
    mem_model mem_i (.core_clk(core_clk), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .mem_rdata(mem_rdata));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ld(input logic [15:0] d, x, s, input logic [3:0] f);
        {load_a, load_b} = d;
        load_x = x;
        load_sp = s;
        load_nzvc = f;
        reg_load = 1'b1;
        @(negedge core_clk);
        reg_load = 1'b0;
    endtask
    // Cycle count is checked from the taking edge to the done pulse
    task automatic run(input logic [7:0] op, input logic [15:0] opd, input int n);
        int k;
        opcode = op;
        operand = opd;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        k = 1;
        while (done !== 1'b1 && k < 40) begin
            @(negedge core_clk);
            k++;
        end
        chk("cycles", 16'(k), 16'(n - 1));
        @(negedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (mem_we === 1'b1 || mem_re === 1'b1) bus_n++;
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {start, reg_load, opcode, operand, pc, rel_offset} = '0;
        {load_a, load_b, load_x, load_sp, load_nzvc} = '0;
        cx = '{8'h8c, 8'h9c, 8'hac, 8'hbc};
        reset = 1'b1;
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        chk("sp_rst", sp, 16'h00ff);
        chk("d_rst", {acc_a, acc_b}, 16'h0000);
        $display("test reset done");
        // Offsets at both signed extremes, carry and borrow into high byte
        ld(16'h0000, 16'h0000, 16'h00ff, 4'ha);
        pc = 16'h10f0;
        rel_offset = 8'h7f;
        b0 = bus_n;
        run(8'h21, 16'h0000, 3);
        chk("tgt_up", target, 16'h1171);
        pc = 16'h1001;
        rel_offset = 8'h80;
        run(8'h21, 16'h0000, 3);
        chk("tgt_dn", target, 16'h0f83);
        chk("brn_bus", 16'(bus_n - b0), 16'h0000);
        chk("brn_flags", {12'h000, nzvc}, 16'h000a);
        $display("test branch done");
        ld(16'h0020, 16'h12f0, 16'h00ff, 4'ha);
        run(8'h3a, 16'h0000, 3);
        chk("abx_x", ix, 16'h1310);
        chk("abx_f", {12'h000, nzvc}, 16'h000a);
        ld(16'h8001, 16'h0000, 16'h00ff, 4'h0);
        run(8'h05, 16'h0000, 3);
        chk("double_shift_left", {acc_a, acc_b}, 16'h0002);
        chk("double_shift_left_c", {15'h0000, nzvc[0]}, 16'h0001);
        ld(16'h8001, 16'h0000, 16'h00ff, 4'h0);
        run(8'h04, 16'h0000, 3);
        chk("double_shift_right", {acc_a, acc_b}, 16'h4000);
        chk("double_shift_right_c", {15'h0000, nzvc[0]}, 16'h0001);
        ld(16'hfffe, 16'h0000, 16'h00ff, 4'h0);
        run(8'h3d, 16'h0000, 10);
        chk("mul", {acc_a, acc_b}, 16'hfd02);
        $display("test accumulator done");
        ld(16'h0000, 16'hbeef, 16'h0080, 4'h0);
        run(8'h3c, 16'h0000, 4);
        chk("psh_lo", {8'h00, mem_i.mem[16'h0080]}, 16'h00ef);
        chk("psh_hi", {8'h00, mem_i.mem[16'h007f]}, 16'h00be);
        chk("psh_sp", sp, 16'h007e);
        ld(16'h0000, 16'h0000, 16'h007e, 4'h0);
        run(8'h38, 16'h0000, 5);
        chk("pul_x", ix, 16'hbeef);
        chk("pul_sp", sp, 16'h0080);
        ld(16'h0000, 16'h1000, 16'h00ff, 4'h5);
        run(8'h35, 16'h0000, 3);
        chk("txs", sp, 16'h0fff);
        run(8'h30, 16'h0000, 3);
        chk("tsx", ix, 16'h1000);
        chk("t_flags", {12'h000, nzvc}, 16'h0005);
        $display("test stack done");
        ld(16'h1234, 16'h1000, 16'h00ff, 4'h0);
        run(8'hdd, 16'h0040, 4);
        chk("std_m", {mem_i.mem[16'h0040], mem_i.mem[16'h0041]}, 16'h1234);
        chk("std_d", {acc_a, acc_b}, 16'h1234);
        ld(16'h1000, 16'h1000, 16'h00ff, 4'h0);
        run(8'h93, 16'h0040, 5);
        chk("double_subtract", {acc_a, acc_b}, 16'hfdcc);
        ld(16'h1000, 16'h1000, 16'h00ff, 4'h0);
        run(8'hc3, 16'h1234, 4);
        chk("double_add", {acc_a, acc_b}, 16'h2234);
        run(8'hdc, 16'h0040, 4);
        chk("ldd_m", {acc_a, acc_b}, 16'h1234);
        run(8'hcc, 16'h8000, 3);
        chk("ldd_f", {12'h000, nzvc}, 16'h0008);
        // Every addressing form, same word, borrow out sets N and C
        for (int i = 0; i < 4; i++) begin
            ld(16'h0000, 16'h1000, 16'h00ff, 4'h6);
            run(cx[i], (i == 0) ? 16'h1234 : 16'h0040, (i < 2) ? 4 + i : 6);
            chk("cpx_f", {12'h000, nzvc}, 16'h0009);
        end
        $display("test memory done");
        ld(16'h5566, 16'h7788, 16'h0099, 4'h3);
        b0 = bus_n;
        opcode = 8'h01;
        start = 1'b1;
        @(negedge core_clk);
        chk("claim", {15'h0000, claimed}, 16'h0000);
        start = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("f_busy", {15'h0000, busy}, 16'h0000);
        chk("f_d", {acc_a, acc_b}, 16'h5566);
        chk("f_x", ix, 16'h7788);
        chk("f_sp", sp, 16'h0099);
        chk("f_bus", 16'(bus_n - b0), 16'h0000);
        $display("test foreign done");
        end_of_test();
    end
endmodule
`default_nettype wire
